// File: artt_timer_two.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "artt_defs.svh"
// Functional notes
// (R01) mode bit picks absolute or relative layouts
// (R02) absolute: word0 bits 13-8 cycle value
// (R03) absolute: word0 bits 5-0 cycle mask
// (R04) absolute: word1 bits 13-0 macrotick offset
// (R05) relative: word0 is count bits 31:16
// (R06) relative: word1 is count bits 15:0
// (R07) absolute: config writes act immediately
// (R08) relative: config writes apply after expiry
// (R09) start/stop trigger bits 9/10, zero ignored
// (R10) bit 8 reads idle 0, running 1
// (R11) bit 12 selects one-shot or repeat
// (R12) leaving normal operation stops timer at once
// (R13) expiry on cycle/offset match or count
// (R14) expiry sets flag; one-shot returns idle
module artt_timer_two (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // register bus
   input wire artt_pkg::artt_axi_req_type axi_req,
   output wire artt_pkg::artt_axi_rsp_type axi_rsp,
   // protocol engine timebase
   input wire artt_pkg::artt_timebase_type tbase,
   // timer status
   output wire logic t2_running,
   output logic t2_expired
);
   import artt_pkg::*;

   typedef enum logic {ST_IDLE, ST_RUN} artt_state_type;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   artt_state_type state_r, state_nxt;
   artt_mode_type second_timer_mode_select;
   logic second_timer_repeat_mode;
   logic [15:0] timer_two_config_word0;
   logic [15:0] timer_two_config_word1;
   logic [31:0] cnt_r, cnt_nxt;
   logic expire_nxt;
   logic exp_flag_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire logic wr_go = axi_req.awvalid & axi_req.wvalid & ~bvalid_r;
   wire logic wr_ctrl = wr_go & (axi_req.awaddr == `ARTT_OFS_CTRL);
   wire logic wr_cfg0 = wr_go & (axi_req.awaddr == `ARTT_OFS_CFG0);
   wire logic wr_cfg1 = wr_go & (axi_req.awaddr == `ARTT_OFS_CFG1);
   wire logic wr_stat = wr_go & (axi_req.awaddr == `ARTT_OFS_STAT);
   wire logic wr_hit = wr_ctrl | wr_cfg0 | wr_cfg1 | wr_stat;
   wire logic [15:0] wmask = {{8{axi_req.wstrb[1]}}, {8{axi_req.wstrb[0]}}};
   wire logic [15:0] wdat = axi_req.wdata[15:0];
   // only a one in a trigger bit acts, a zero is ignored
   wire logic start_trig = wr_ctrl & axi_req.wstrb[1] & wdat[`ARTT_CTRL_START]; // see (R09)
   wire logic stop_trig = wr_ctrl & axi_req.wstrb[1] & wdat[`ARTT_CTRL_STOP]; // see (R09)
   wire logic flag_clr = wr_stat & axi_req.wstrb[0] & wdat[`ARTT_STAT_EXP];

   // ----------------------------------------
   // config field views
   // ----------------------------------------
   wire logic [5:0] second_timer_cycle_value =
      timer_two_config_word0[`ARTT_CYC_VAL_HI:`ARTT_CYC_VAL_LO]; // see (R02)
   wire logic [5:0] second_timer_cycle_mask =
      timer_two_config_word0[`ARTT_CYC_MSK_HI:`ARTT_CYC_MSK_LO]; // see (R03)
   wire logic [13:0] second_timer_macrotick_offset =
      timer_two_config_word1[`ARTT_MT_OFS_HI:0]; // see (R04)
   wire logic [31:0] second_timer_macrotick_count =
      {timer_two_config_word0, timer_two_config_word1}; // see (R05) see (R06)
   // live register fields feed the compare, so a write retargets the next match
   wire logic abs_match = tbase.mt_tick
      & ((tbase.cycle & second_timer_cycle_mask) == (second_timer_cycle_value & second_timer_cycle_mask))
      & (tbase.macrotick == second_timer_macrotick_offset); // see (R07) see (R13)
   wire logic rel_last = tbase.mt_tick & (cnt_r <= 32'h0000_0001); // see (R13)
   wire logic is_abs = (second_timer_mode_select == ARTT_MODE_ABS); // see (R01)

   // ----------------------------------------
   // timer state machine
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      expire_nxt = 1'b0;
      if (!tbase.poc_normal) begin
         state_nxt = ST_IDLE; // see (R12)
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_trig && !stop_trig) begin
                  state_nxt = ST_RUN; // see (R09)
                  cnt_nxt = second_timer_macrotick_count;
               end
            end
            ST_RUN: begin
               if (stop_trig) begin
                  state_nxt = ST_IDLE; // see (R09)
               end else if (start_trig) begin
                  cnt_nxt = second_timer_macrotick_count;
               end else if (is_abs) begin
                  if (abs_match) begin
                     expire_nxt = 1'b1; // see (R13)
                     if (!second_timer_repeat_mode) begin
                        state_nxt = ST_IDLE; // see (R11) see (R14)
                     end
                  end
               end else if (rel_last) begin
                  expire_nxt = 1'b1;
                  // the period in flight kept its own copy; new words load here or on a start trigger
                  cnt_nxt = second_timer_macrotick_count; // see (R08)
                  if (!second_timer_repeat_mode) begin
                     state_nxt = ST_IDLE; // see (R11) see (R14)
                  end
               end else if (tbase.mt_tick) begin
                  cnt_nxt = cnt_r - 32'h0000_0001;
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         cnt_r <= 32'h0000_0000;
         t2_expired <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         t2_expired <= expire_nxt;
      end
   end

   assign t2_running = (state_r == ST_RUN); // see (R10)

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         second_timer_mode_select <= ARTT_MODE_ABS;
         second_timer_repeat_mode <= 1'b0;
         timer_two_config_word0 <= `ARTT_CFG_RST;
         timer_two_config_word1 <= `ARTT_CFG_RST;
      end else begin
         if (wr_ctrl && axi_req.wstrb[1]) begin
            second_timer_mode_select <= artt_mode_type'(wdat[`ARTT_CTRL_MODE]); // see (R01)
            second_timer_repeat_mode <= wdat[`ARTT_CTRL_REP]; // see (R11)
         end
         if (wr_cfg0) begin
            timer_two_config_word0 <= (wdat & wmask) | (timer_two_config_word0 & ~wmask);
         end
         if (wr_cfg1) begin
            timer_two_config_word1 <= (wdat & wmask) | (timer_two_config_word1 & ~wmask);
         end
      end
   end

   // set wins over a clear arriving in the same cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         exp_flag_r <= 1'b0;
      end else begin
         exp_flag_r <= expire_nxt | (exp_flag_r & ~flag_clr); // see (R14)
      end
   end

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   wire logic rd_go = axi_req.arvalid & ~rvalid_r;
   wire logic [15:0] ctrl_view = {2'h0, second_timer_mode_select, second_timer_repeat_mode,
      3'h0, t2_running, 8'h00}; // see (R10)
   wire logic [15:0] rd_val = (axi_req.araddr == `ARTT_OFS_CTRL) ? ctrl_view :
      (axi_req.araddr == `ARTT_OFS_CFG0) ? timer_two_config_word0 :
      (axi_req.araddr == `ARTT_OFS_CFG1) ? timer_two_config_word1 :
      (axi_req.araddr == `ARTT_OFS_STAT) ? {15'h0000, exp_flag_r} : 16'h0000;
   wire logic rd_hit = (axi_req.araddr == `ARTT_OFS_CTRL) | (axi_req.araddr == `ARTT_OFS_CFG0)
      | (axi_req.araddr == `ARTT_OFS_CFG1) | (axi_req.araddr == `ARTT_OFS_STAT);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_r <= 1'b0;
         bresp_r <= `ARTT_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `ARTT_RESP_OKAY : `ARTT_RESP_SLVERR;
      end else if (axi_req.bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `ARTT_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= {16'h0000, rd_val};
         rresp_r <= rd_hit ? `ARTT_RESP_OKAY : `ARTT_RESP_SLVERR;
      end else if (axi_req.rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign axi_rsp.awready = wr_go;
   assign axi_rsp.wready = wr_go;
   assign axi_rsp.bvalid = bvalid_r;
   assign axi_rsp.bresp = bresp_r;
   assign axi_rsp.arready = rd_go;
   assign axi_rsp.rvalid = rvalid_r;
   assign axi_rsp.rdata = rdata_r;
   assign axi_rsp.rresp = rresp_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_rel_step;
      t2_running && !is_abs && tbase.poc_normal && tbase.mt_tick && !start_trig && !stop_trig;
   endsequence
   sequence s_rel_quiet;
      t2_running && !is_abs && tbase.poc_normal && !tbase.mt_tick && !start_trig && !stop_trig;
   endsequence

   a_poc_leave_stop: assert property (!tbase.poc_normal |=> !t2_running) // see (R12)
      else $error("timer kept running outside normal operation");
   a_start_trigger_run: assert property (start_trig && !stop_trig && tbase.poc_normal |=> t2_running) // see (R09)
      else $error("start trigger did not start the timer");
   a_stop_trigger_idle: assert property (stop_trig |=> !t2_running) // see (R09)
      else $error("stop trigger did not stop the timer");
   a_state_bit_read: assert property (rd_go && axi_req.araddr == `ARTT_OFS_CTRL
      |=> rvalid_r && rdata_r[`ARTT_CTRL_STATE] == $past(t2_running)) // see (R10)
      else $error("state bit read back wrong");
   a_abs_match_expire: assert property (t2_running && is_abs && abs_match && tbase.poc_normal
      && !start_trig && !stop_trig |=> t2_expired) // see (R13)
      else $error("absolute match gave no expiry");
   a_abs_no_false: assert property (t2_running && is_abs && !abs_match |=> !t2_expired) // see (R01)
      else $error("absolute timer expired without a match");
   a_rel_count_step: assert property (s_rel_step ##0 (cnt_r > 32'h0000_0001)
      |=> cnt_r == $past(cnt_r) - 32'h0000_0001) // see (R13)
      else $error("relative count did not step");
   a_rel_write_hold: assert property (s_rel_quiet ##0 (wr_cfg0 || wr_cfg1) |=> cnt_r == $past(cnt_r)) // see (R08)
      else $error("config write disturbed the running period");
   a_rel_reload_val: assert property (s_rel_step ##0 rel_last
      |=> t2_expired && cnt_r == $past(second_timer_macrotick_count)) // see (R05)
      else $error("relative reload value wrong");
   a_oneshot_idle: assert property (t2_running && expire_nxt && !second_timer_repeat_mode
      |=> !t2_running ##1 !t2_expired) // see (R11)
      else $error("one-shot timer did not return to idle");
   a_expiry_flag_set: assert property (t2_expired |-> exp_flag_r) // see (R14)
      else $error("expiry flag not set");
   // the flag is judged where software sees it, through the read path
   a_expiry_flag_read: assert property (rd_go && axi_req.araddr == `ARTT_OFS_STAT
      |=> rvalid_r && rdata_r[`ARTT_STAT_EXP] == $past(exp_flag_r)) // see (R14)
      else $error("expiry flag read back wrong");

endmodule : artt_timer_two

// File: artt_defs.svh
`ifndef ARTT_DEFS_SVH
`define ARTT_DEFS_SVH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define ARTT_ADDR_W 8
`define ARTT_DATA_W 32
`define ARTT_RESP_OKAY 2'h0
`define ARTT_RESP_SLVERR 2'h2
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ARTT_OFS_CTRL 8'h00
`define ARTT_OFS_CFG0 8'h04
`define ARTT_OFS_CFG1 8'h08
`define ARTT_OFS_STAT 8'h0c
// ----------------------------------------
// control and status register fields
// ----------------------------------------
`define ARTT_CTRL_STATE 8
`define ARTT_CTRL_START 9
`define ARTT_CTRL_STOP 10
`define ARTT_CTRL_REP 12
`define ARTT_CTRL_MODE 13
`define ARTT_STAT_EXP 0
// ----------------------------------------
// config field positions, reset values
// ----------------------------------------
`define ARTT_CYC_VAL_HI 13
`define ARTT_CYC_VAL_LO 8
`define ARTT_CYC_MSK_HI 5
`define ARTT_CYC_MSK_LO 0
`define ARTT_MT_OFS_HI 13
`define ARTT_CFG_RST 16'h0000
`endif

// File: artt_pkg.sv
package artt_pkg;
`include "artt_defs.svh"
   typedef struct packed {
      logic awvalid;
      logic [`ARTT_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [`ARTT_DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [`ARTT_ADDR_W-1:0] araddr;
      logic rready;
   } artt_axi_req_type;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [`ARTT_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } artt_axi_rsp_type;
   typedef struct packed {
      logic [5:0] cycle;
      logic [13:0] macrotick;
      logic mt_tick;
      logic poc_normal;
   } artt_timebase_type;
   typedef enum logic {ARTT_MODE_ABS, ARTT_MODE_REL} artt_mode_type;
endpackage : artt_pkg

// File: tb.sv
`timescale 1ns/1ns
`include "artt_defs.svh"
module tb;
   import artt_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic sys_clk;
   logic rst_b;
   artt_axi_req_type req;
   artt_axi_rsp_type rsp;
   artt_timebase_type tbase;
   logic t2_running;
   logic t2_expired;
   int failures;
   int num_checks;
   logic [31:0] rdat;
   logic [1:0] resp;
   artt_timer_two u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .tbase(tbase),
      .t2_running(t2_running), .t2_expired(t2_expired));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         failures++;
      end
   endtask : chk
   // ready is combinational, so it is looked at mid-cycle and the transfer completes at the next edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:d, wstrb:4'hf, bready:1'b1, default:'0};
      @(negedge sys_clk);
      while (!(rsp.awready && rsp.wready)) @(negedge sys_clk);
      @(posedge sys_clk);
      req.awvalid <= 1'b0;
      req.wvalid <= 1'b0;
      @(negedge sys_clk);
      while (rsp.bvalid !== 1'b1) @(negedge sys_clk);
      resp = rsp.bresp;
      @(posedge sys_clk);
      req.bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge sys_clk);
      req <= '{arvalid:1'b1, araddr:a, rready:1'b1, default:'0};
      @(negedge sys_clk);
      while (rsp.arready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
      req.arvalid <= 1'b0;
      @(negedge sys_clk);
      while (rsp.rvalid !== 1'b1) @(negedge sys_clk);
      rdat = rsp.rdata;
      resp = rsp.rresp;
      @(posedge sys_clk);
      req.rready <= 1'b0;
   endtask : rd
   task rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
      rd(a);
      chk(n, e, rdat);
   endtask : rdchk
   // one macrotick pulse, then the registered expiry pulse is judged
   task mt(input logic [5:0] c, input logic [13:0] m, input logic e);
      @(posedge sys_clk);
      tbase.cycle <= c;
      tbase.macrotick <= m;
      tbase.mt_tick <= 1'b1;
      @(posedge sys_clk);
      tbase.mt_tick <= 1'b0;
      @(negedge sys_clk);
      chk("expired", {31'h0, e}, {31'h0, t2_expired});
   endtask : mt
   task run(input logic e);
      @(negedge sys_clk);
      chk("running", {31'h0, e}, {31'h0, t2_running});
   endtask : run
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      rdchk(`ARTT_OFS_CTRL, 32'h0, "ctrl reset");
      rdchk(`ARTT_OFS_CFG0, 32'h0, "cfg0 reset");
      rdchk(`ARTT_OFS_CFG1, 32'h0, "cfg1 reset");
      wr(`ARTT_OFS_CFG0, 32'hffffffff);
      rdchk(`ARTT_OFS_CFG0, 32'h0000ffff, "cfg0 rw");
      chk("read resp", {30'h0, `ARTT_RESP_OKAY}, {30'h0, resp});
      wr(8'h10, 32'h0000ffff);
      chk("unmapped bresp", {30'h0, `ARTT_RESP_SLVERR}, {30'h0, resp});
      rdchk(8'h10, 32'h0, "unmapped data");
      chk("unmapped rresp", {30'h0, `ARTT_RESP_SLVERR}, {30'h0, resp});
      $display("test regs done");
   endtask : t_regs
   task t_abs;
      wr(`ARTT_OFS_CFG0, 32'h0000050f);
      wr(`ARTT_OFS_CFG1, 32'h00000123);
      wr(`ARTT_OFS_CTRL, 32'h00000200);
      run(1'b1);
      rdchk(`ARTT_OFS_CTRL, 32'h00000100, "state bit");
      mt(6'h06, 14'h0123, 1'b0);
      wr(`ARTT_OFS_CFG1, 32'h00000200);
      mt(6'h05, 14'h0123, 1'b0);
      mt(6'h15, 14'h0200, 1'b1);
      run(1'b0);
      rdchk(`ARTT_OFS_STAT, 32'h1, "flag set");
      wr(`ARTT_OFS_STAT, 32'h1);
      rdchk(`ARTT_OFS_STAT, 32'h0, "flag clear");
      $display("test absolute done");
   endtask : t_abs
   task t_rel;
      wr(`ARTT_OFS_CFG0, 32'h0);
      wr(`ARTT_OFS_CFG1, 32'h3);
      wr(`ARTT_OFS_CTRL, 32'h00003200);
      wr(`ARTT_OFS_CFG1, 32'h1);
      mt(6'h0, 14'h0, 1'b0);
      mt(6'h0, 14'h1, 1'b0);
      mt(6'h0, 14'h2, 1'b1);
      run(1'b1);
      mt(6'h0, 14'h3, 1'b1);
      wr(`ARTT_OFS_CTRL, 32'h00003000);
      run(1'b1);
      rdchk(`ARTT_OFS_CTRL, 32'h00003100, "ctrl running");
      wr(`ARTT_OFS_CTRL, 32'h00003600);
      run(1'b0);
      wr(`ARTT_OFS_CFG0, 32'h1);
      wr(`ARTT_OFS_CFG1, 32'h0);
      wr(`ARTT_OFS_CTRL, 32'h00002200);
      mt(6'h0, 14'h0, 1'b0);
      mt(6'h0, 14'h1, 1'b0);
      mt(6'h0, 14'h2, 1'b0);
      wr(`ARTT_OFS_CTRL, 32'h00002400);
      run(1'b0);
      $display("test relative done");
   endtask : t_rel
   task t_poc;
      wr(`ARTT_OFS_CTRL, 32'h00000200);
      run(1'b1);
      @(posedge sys_clk);
      tbase.poc_normal <= 1'b0;
      @(posedge sys_clk);
      run(1'b0);
      wr(`ARTT_OFS_CTRL, 32'h00000200);
      run(1'b0);
      @(posedge sys_clk);
      tbase.poc_normal <= 1'b1;
      $display("test protocol state done");
   endtask : t_poc
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task results;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // tests take under two hundred cycles; this bound of 20000 cycles is far beyond that
   initial begin
      #200000;
      failures++;
      results;
   end
   initial begin
      failures = 0;
      num_checks = 0;
      rst_b = 1'b0;
      req = '0;
      tbase = '0;
      tbase.poc_normal = 1'b1;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs;
      t_abs;
      t_rel;
      t_poc;
      results;
   end
endmodule : tb
